// file: ocpc_pkg.sv
`default_nettype none
package ocpc_pkg;
    // ***********************************************
    // register map (byte addresses)
    // ***********************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_COMPARE = 4'h4;
    localparam logic [3:0] ADDR_COUNTER = 4'h8;
    localparam logic [3:0] ADDR_TIMER_CTRL = 4'hC;
    // ***********************************************
    // compare_output_control fields
    // ***********************************************
    localparam int BIT_AUTO_ADD = 6;
    localparam int BIT_REG_SELECT = 4;
    localparam int BIT_OUT_ENABLE_A = 3;
    localparam int BIT_OUT_ENABLE_B = 2;
    localparam int BIT_LEVEL_A = 1;
    localparam int BIT_LEVEL_B = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h5F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ***********************************************
    // timer_control_status fields
    // ***********************************************
    localparam int BIT_CLEAR_ON_MATCH_A = 0;
    // ***********************************************
    // reset values and bus answers
    // ***********************************************
    localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ocpc_pkg
`default_nettype wire

// file: ocpc_output_compare.sv
`timescale 1ns/1ps
`default_nettype none
module ocpc_output_compare #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [3:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [3:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // compare pins and match pulses
    output logic compareAPin,
    output logic compareAPinOeN,
    output logic compareBPin,
    output logic compareBPinOeN,
    output logic compareMatchA,
    output logic compareMatchB
);
    // ***********************************************
    // bus slave
    // ***********************************************
    logic awHeld_q, wHeld_q, bValid_q, rValid_q;
    logic [3:0] awAddr_q, wStrb_q;
    logic [31:0] wData_q, rData_q;
    logic [1:0] bResp_q, rResp_q;
    logic [7:0] ctrl_q;
    logic clearOnMatchA_q;
    logic [CNT_W-1:0] counter_q;
    logic [CNT_W-1:0] compareValue_q [2];
    logic [1:0] cmpWrLast_q, pinLevel_q, match;

    wire doWrite = awHeld_q && wHeld_q && !bValid_q;
    wire awOk = (awAddr_q == ocpc_pkg::ADDR_CTRL) || (awAddr_q == ocpc_pkg::ADDR_COMPARE)
        || (awAddr_q == ocpc_pkg::ADDR_COUNTER) || (awAddr_q == ocpc_pkg::ADDR_TIMER_CTRL);
    wire wrCtrl = doWrite && (awAddr_q == ocpc_pkg::ADDR_CTRL) && wStrb_q[0];
    wire wrCompare = doWrite && (awAddr_q == ocpc_pkg::ADDR_COMPARE);
    wire wrCounter = doWrite && (awAddr_q == ocpc_pkg::ADDR_COUNTER);
    wire wrTimerCtrl = doWrite && (awAddr_q == ocpc_pkg::ADDR_TIMER_CTRL) && wStrb_q[0];
    wire regSelect = ctrl_q[ocpc_pkg::BIT_REG_SELECT];
    wire autoAdd = ctrl_q[ocpc_pkg::BIT_AUTO_ADD];
    wire [CNT_W-1:0] selCompare = regSelect ? compareValue_q[1] : compareValue_q[0];
    wire [CNT_W-1:0] mergedCompare = {wStrb_q[1] ? wData_q[15:8] : selCompare[15:8],
        wStrb_q[0] ? wData_q[7:0] : selCompare[7:0]};
    wire [CNT_W-1:0] mergedCounter = {wStrb_q[1] ? wData_q[15:8] : counter_q[15:8],
        wStrb_q[0] ? wData_q[7:0] : counter_q[7:0]};
    wire arOk = (s_axi_araddr == ocpc_pkg::ADDR_CTRL) || (s_axi_araddr == ocpc_pkg::ADDR_COMPARE)
        || (s_axi_araddr == ocpc_pkg::ADDR_COUNTER)
        || (s_axi_araddr == ocpc_pkg::ADDR_TIMER_CTRL);
    wire [31:0] readMux =
        (s_axi_araddr == ocpc_pkg::ADDR_CTRL) ? {24'h000000, ctrl_q} :
        (s_axi_araddr == ocpc_pkg::ADDR_COMPARE) ? {16'h0000, selCompare} :
        (s_axi_araddr == ocpc_pkg::ADDR_COUNTER) ? {16'h0000, counter_q} :
        (s_axi_araddr == ocpc_pkg::ADDR_TIMER_CTRL) ? {31'h00000000, clearOnMatchA_q} :
        32'h00000000;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            awHeld_q <= 1'b0;
            awAddr_q <= 4'h0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end
        else if (doWrite)
            awHeld_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
        else if (doWrite)
            wHeld_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            bValid_q <= 1'b0;
            bResp_q <= ocpc_pkg::RESP_OKAY;
        end
        else if (doWrite)
        begin
            bValid_q <= 1'b1;
            bResp_q <= awOk ? ocpc_pkg::RESP_OKAY : ocpc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bValid_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rValid_q <= 1'b0;
            rData_q <= 32'h00000000;
            rResp_q <= ocpc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_q <= 1'b1;
            rData_q <= readMux;
            rResp_q <= arOk ? ocpc_pkg::RESP_OKAY : ocpc_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rValid_q <= 1'b0;
    end

    // ***********************************************
    // control registers
    // ***********************************************
    // unused bits 7 and 5 of the control byte are masked off on write; read zero
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q <= ocpc_pkg::CTRL_RESET;
            clearOnMatchA_q <= 1'b0;
        end
        else
        begin
            if (wrCtrl)
                ctrl_q <= wData_q[7:0] & ocpc_pkg::CTRL_WRITE_MASK;
            if (wrTimerCtrl)
                clearOnMatchA_q <= wData_q[ocpc_pkg::BIT_CLEAR_ON_MATCH_A];
        end
    end

    // ***********************************************
    // free-running counter
    // ***********************************************
    // a clear beats a pending write, a write beats the increment
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            counter_q <= ocpc_pkg::COUNTER_RESET;
        else if (match[0] && clearOnMatchA_q)
            counter_q <= '0;
        else if (wrCounter)
            counter_q <= mergedCounter;
        else
            counter_q <= counter_q + 1'b1;
    end

    // ***********************************************
    // compare channels
    // ***********************************************
    wire [1:0] levelBit = {ctrl_q[ocpc_pkg::BIT_LEVEL_B], ctrl_q[ocpc_pkg::BIT_LEVEL_A]};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_channel
            // channels run the same whatever the select bit holds
            wire chWrite = wrCompare && (regSelect == 1'(ch));
            // a write in the previous cycle wins over a match on the new value
            assign match[ch] = (counter_q == compareValue_q[ch]) && !cmpWrLast_q[ch];
            wire chLevel = (ch == 0 && autoAdd) ? !pinLevel_q[ch] : levelBit[ch];

            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    compareValue_q[ch] <= ocpc_pkg::COMPARE_RESET;
                    cmpWrLast_q[ch] <= 1'b0;
                    pinLevel_q[ch] <= 1'b0;
                end
                else
                begin
                    cmpWrLast_q[ch] <= chWrite;
                    if (chWrite)
                        compareValue_q[ch] <= mergedCompare;
                    if (match[ch])
                        pinLevel_q[ch] <= chLevel;
                end
            end
        end
    endgenerate

    assign compareAPin = pinLevel_q[0];
    assign compareBPin = pinLevel_q[1];
    assign compareAPinOeN = !ctrl_q[ocpc_pkg::BIT_OUT_ENABLE_A];
    assign compareBPinOeN = !ctrl_q[ocpc_pkg::BIT_OUT_ENABLE_B];
    assign compareMatchA = match[0];
    assign compareMatchB = match[1];

    // ***********************************************
    // assertions
    // ***********************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_route_select;
        (wrCompare && wStrb_q[1:0] == 2'h3 && !regSelect)
            |=> compareValue_q[0] == $past(wData_q[15:0]);
    endproperty
    a_route_select: assert property (p_route_select) else $error("select 0 missed reg A");

    property p_select_harmless;
        (wrCtrl && !wrCompare) |=> $stable(compareValue_q[0]) && $stable(compareValue_q[1]);
    endproperty
    a_select_harmless: assert property (p_select_harmless) else $error("select changed compare");

    property p_enable_a;
        wrCtrl |=> compareAPinOeN == !$past(wData_q[ocpc_pkg::BIT_OUT_ENABLE_A]);
    endproperty
    a_enable_a: assert property (p_enable_a) else $error("pin A enable wrong");
    property p_enable_b;
        wrCtrl |=> compareBPinOeN == !$past(wData_q[ocpc_pkg::BIT_OUT_ENABLE_B]);
    endproperty
    a_enable_b: assert property (p_enable_b) else $error("pin B enable wrong");
    property p_level_a;
        (compareMatchA && !autoAdd) |=> compareAPin == $past(ctrl_q[ocpc_pkg::BIT_LEVEL_A]);
    endproperty
    a_level_a: assert property (p_level_a) else $error("pin A level wrong");
    property p_auto_ignores;
        (compareMatchA && autoAdd) |=> compareAPin != $past(compareAPin);
    endproperty
    a_auto_ignores: assert property (p_auto_ignores) else $error("level A not ignored");
    property p_level_b;
        compareMatchB |=> compareBPin == $past(ctrl_q[ocpc_pkg::BIT_LEVEL_B]);
    endproperty
    a_level_b: assert property (p_level_b) else $error("pin B level wrong");
    property p_match_equal;
        compareMatchA |-> counter_q == compareValue_q[0] ##1 counter_q != $past(counter_q);
    endproperty
    a_match_equal: assert property (p_match_equal) else $error("match A not at last equal state");
    property p_clear_a;
        (compareMatchA && clearOnMatchA_q) |=> counter_q == '0;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("counter not cleared on match A");
    property p_reset_ctrl;
        $past(sys_rst) |-> ctrl_q == ocpc_pkg::CTRL_RESET && compareAPinOeN && compareBPinOeN;
    endproperty
    a_reset_ctrl: assert property (@(posedge ref_clk) p_reset_ctrl) else $error("bad reset");

    c_match_a: cover property (compareMatchA && !compareAPinOeN);
    c_match_b: cover property (compareMatchB && !compareBPinOeN);
    c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
    c_read_resp: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ocpc_output_compare
`default_nettype wire

// file: ocpc_output_compare_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ocpc_output_compare_tb_top;
    typedef struct {logic [31:0] wr; logic [31:0] rd; logic oeAN; logic oeBN;} ocpc_row_s;
    // ****
    // stimulus and observed signals
    // ****
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [3:0] awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'hF;
    logic [31:0] wData = 32'h0, rData;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, resp;
    logic pinA, pinAOeN, pinB, pinBOeN, matchA, matchB;
    logic [31:0] rd;
    int errors = 0, totalChecks = 0, c;
    // bits 7 and 5 are not writable and read back as zero
    ocpc_row_s rows [5] = '{'{32'h08, 32'h08, 1'b0, 1'b1}, '{32'h04, 32'h04, 1'b1, 1'b0},
        '{32'h0C, 32'h0C, 1'b0, 1'b0}, '{32'hFF, 32'h5F, 1'b0, 1'b0}, '{32'h00, 32'h00, 1'b1, 1'b1}};
    always #2.5 ref_clk = ~ref_clk;
    ocpc_output_compare i_ocpc_output_compare (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .compareAPin(pinA), .compareAPinOeN(pinAOeN), .compareBPin(pinB),
        .compareBPinOeN(pinBOeN), .compareMatchA(matchA), .compareMatchB(matchB));
    // ****
    // helpers
    // ****
    task automatic print_verdict();
        if (errors == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk
    task automatic hang(input int n);
        if (n >= 300)
        begin
            errors++;
            print_verdict();
        end
    endtask : hang
    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic awDone, wDone, got;
        int n;
        awDone = 1'b0;
        wDone = 1'b0;
        got = 1'b0;
        @(posedge ref_clk);
        awValid <= 1'b1;
        wValid <= 1'b1;
        awAddr <= a;
        wData <= d;
        bReady <= 1'b1;
        for (n = 0; n < 300 && !got; n++)
        begin
            @(posedge ref_clk);
            if (awValid && !awDone && awReady === 1'b1)
            begin
                awDone = 1'b1;
                awValid <= 1'b0;
            end
            if (wValid && !wDone && wReady === 1'b1)
            begin
                wDone = 1'b1;
                wValid <= 1'b0;
            end
            if (bValid === 1'b1)
            begin
                got = 1'b1;
                resp = bResp;
                bReady <= 1'b0;
            end
        end
        hang(n);
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a);
        logic arDone, got;
        int n;
        arDone = 1'b0;
        got = 1'b0;
        @(posedge ref_clk);
        arValid <= 1'b1;
        arAddr <= a;
        rReady <= 1'b1;
        for (n = 0; n < 300 && !got; n++)
        begin
            @(posedge ref_clk);
            if (!arDone && arReady === 1'b1)
            begin
                arDone = 1'b1;
                arValid <= 1'b0;
            end
            if (rValid === 1'b1)
            begin
                got = 1'b1;
                rd = rData;
                resp = rResp;
                rReady <= 1'b0;
            end
        end
        hang(n);
    endtask : axi_read
    // counts falling edges up to and including the next match of one channel
    task automatic wait_match(input logic chB, output int cnt);
        for (cnt = 1; cnt < 300; cnt++)
        begin
            @(negedge ref_clk);
            if ((chB ? matchB : matchA) === 1'b1)
                break;
        end
        hang(cnt);
    endtask : wait_match
    // ****
    // main sequence
    // ****
    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        chk("oeA", 32'h1, {31'h0, pinAOeN});
        chk("oeB", 32'h1, {31'h0, pinBOeN});
        axi_read(ocpc_pkg::ADDR_CTRL);
        chk("ctrlReset", 32'h0, rd);
        foreach (rows[i])
        begin
            axi_write(ocpc_pkg::ADDR_CTRL, rows[i].wr);
            chk("ctrlResp", {30'h0, ocpc_pkg::RESP_OKAY}, {30'h0, resp});
            axi_read(ocpc_pkg::ADDR_CTRL);
            chk("rdResp", {30'h0, ocpc_pkg::RESP_OKAY}, {30'h0, resp});
            chk("ctrlRead", rows[i].rd, rd);
            chk("oeA", {31'h0, rows[i].oeAN}, {31'h0, pinAOeN});
            chk("oeB", {31'h0, rows[i].oeBN}, {31'h0, pinBOeN});
        end
        axi_write(4'h2, 32'hFFFF_FFFF);
        chk("badResp", {30'h0, ocpc_pkg::RESP_SLVERR}, {30'h0, resp});
        // both compare registers share one address; the select bit steers it
        axi_write(ocpc_pkg::ADDR_CTRL, 32'h10);
        axi_write(ocpc_pkg::ADDR_COMPARE, 32'h20);
        axi_read(ocpc_pkg::ADDR_COMPARE);
        chk("cmpB", 32'h20, rd);
        axi_write(ocpc_pkg::ADDR_CTRL, 32'h0F);
        axi_write(ocpc_pkg::ADDR_COMPARE, 32'h40);
        axi_read(ocpc_pkg::ADDR_COMPARE);
        chk("cmpA", 32'h40, rd);
        axi_write(ocpc_pkg::ADDR_TIMER_CTRL, 32'h1);
        axi_write(ocpc_pkg::ADDR_COUNTER, 32'h0);
        wait_match(1'b1, c);
        @(negedge ref_clk);
        chk("pinBHigh", 32'h1, {31'h0, pinB});
        wait_match(1'b0, c);
        @(negedge ref_clk);
        chk("pinAHigh", 32'h1, {31'h0, pinA});
        // software inverts both levels; select moved to B must not disturb matching
        axi_write(ocpc_pkg::ADDR_CTRL, 32'h1C);
        wait_match(1'b0, c);
        wait_match(1'b0, c);
        chk("periodA", 32'd65, 32'(c));
        @(negedge ref_clk);
        chk("pinALow", 32'h0, {31'h0, pinA});
        wait_match(1'b1, c);
        @(negedge ref_clk);
        chk("pinBLow", 32'h0, {31'h0, pinB});
        // auto-add mode: level A held at 1, pin must still toggle
        axi_write(ocpc_pkg::ADDR_CTRL, 32'h4E);
        wait_match(1'b0, c);
        @(negedge ref_clk);
        chk("pinAToggle1", 32'h1, {31'h0, pinA});
        wait_match(1'b0, c);
        @(negedge ref_clk);
        chk("pinAToggle2", 32'h0, {31'h0, pinA});
        // a control write without byte lane 0 must leave the control byte alone
        @(posedge ref_clk);
        wStrb <= 4'hE;
        axi_write(ocpc_pkg::ADDR_CTRL, 32'h00);
        wStrb <= 4'hF;
        chk("noLaneResp", {30'h0, ocpc_pkg::RESP_OKAY}, {30'h0, resp});
        axi_read(ocpc_pkg::ADDR_CTRL);
        chk("ctrlKept", 32'h4E, rd);
        // reset in mid-run with both pins enabled
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        chk("oeAReset", 32'h1, {31'h0, pinAOeN});
        chk("oeBReset", 32'h1, {31'h0, pinBOeN});
        axi_read(ocpc_pkg::ADDR_CTRL);
        chk("ctrlReset2", 32'h0, rd);
        print_verdict();
    end
endmodule : ocpc_output_compare_tb_top
`default_nettype wire
